// >>> include/cerr_pkg.sv
// Constants shared by the coprocessor error and mouse request block
// Contract
// (R1) Mode bit 5 high makes the shared pin the coprocessor error input, else request 13.
// (R2) In error mode an active error input raises the level-13 request to the controller.
// (R3) The generated level-13 request stays until a write to port F0h.
// (R4) In error mode ignore-error is never asserted unless the error input is active.
// (R5) Write to F0h with error active asserts ignore-error until error negates.
// (R6) Write to F0h while error is inactive leaves ignore-error deasserted.
// (R7) Ignore-error is driven active only when bit 5 is set.
// (R8) Reset drives the active-low ignore-error output high.
// (R9) After bus reset the error pin is a plain level-13 request.
// (R10) Bit 4 chooses plain request or latched mouse function for the level-12 pin.
// (R11) Mouse mode latches a rising edge on the level-12 pin as a request.
// (R12) Latched mouse request holds until bus reset or read of port 60h.
// (R13) After bus reset the level-12 pin is a plain request.
// (R14) Bit 4 high selects mouse mode; bits 4 and 5 clear on reset.
package cerr_pkg;
  localparam logic [15:0] ERR_PORT_ADDR = 16'h00F0;
  localparam logic [15:0] MOUSE_PORT_ADDR = 16'h0060;
  localparam int MOUSE_SEL_BIT = 4;
  localparam int ERR_SEL_BIT = 5;
  localparam logic [7:0] DIVISOR_CFG_RESET = 8'h00;
  localparam logic IGNORE_RESET_LEVEL = 1'b1;
endpackage : cerr_pkg

// >>> core/coproc_error_mouse_irq.sv
// Coprocessor error / mouse interrupt request logic
`timescale 1ns/100ps
`default_nettype none
module coproc_error_mouse_irq
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Clock divisor configuration and io cycle decode
  input wire logic [7:0] i_divisor_cfg,
  input wire logic i_io_write,
  input wire logic i_io_read_strobe_n,
  input wire logic [15:0] i_io_addr,
  // Pins from outside
  input wire logic i_coproc_error_in_n,
  input wire logic i_mouse_request_pin,
  // Outputs
  output logic o_ignore_error_out_n,
  output logic o_fpu_error_request,
  output logic o_mouse_request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] err_sync;
    logic [1:0] mouse_sync;
    logic [1:0] rd_sync;
    logic mouse_prev;
    logic rd_prev;
    logic err_mode;
    logic mouse_mode;
    logic err_req;
    logic ignore;
    logic mouse_latch;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic err_active;
  logic rd_fall;
  logic err_wr;

  assign err_active = ~state_reg.err_sync[1];
  assign rd_fall = state_reg.rd_prev & ~state_reg.rd_sync[1];
  assign err_wr = i_io_write && (i_io_addr == cerr_pkg::ERR_PORT_ADDR);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.err_sync = {state_reg.err_sync[0], i_coproc_error_in_n};
    state_next.mouse_sync = {state_reg.mouse_sync[0], i_mouse_request_pin};
    state_next.rd_sync = {state_reg.rd_sync[0], i_io_read_strobe_n};
    state_next.mouse_prev = state_reg.mouse_sync[1];
    state_next.rd_prev = state_reg.rd_sync[1];
    state_next.err_mode = i_divisor_cfg[cerr_pkg::ERR_SEL_BIT]; // R1
    state_next.mouse_mode = i_divisor_cfg[cerr_pkg::MOUSE_SEL_BIT]; // R10 R14
    // Error wins over the clearing write in the same cycle
    if (!state_reg.err_mode)
      state_next.err_req = 1'b0;
    else if (err_active)
      state_next.err_req = 1'b1; // R2
    else if (err_wr)
      state_next.err_req = 1'b0; // R3
    if (!state_reg.err_mode || !err_active)
      state_next.ignore = 1'b0; // R4 R7
    else if (err_wr)
      state_next.ignore = 1'b1; // R5
    // Edge sets win over the read that clears
    if (!state_reg.mouse_mode)
      state_next.mouse_latch = 1'b0;
    else if (state_reg.mouse_sync[1] && !state_reg.mouse_prev)
      state_next.mouse_latch = 1'b1; // R11
    else if (rd_fall && i_io_addr == cerr_pkg::MOUSE_PORT_ADDR)
      state_next.mouse_latch = 1'b0; // R12
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Pins default to plain requests after reset
      state_reg <= '0; // R9 R13 R14 R12
      state_reg.err_sync <= 2'h3;
      state_reg.rd_sync <= 2'h3;
      state_reg.rd_prev <= 1'b1;
      state_reg.err_mode <= cerr_pkg::DIVISOR_CFG_RESET[cerr_pkg::ERR_SEL_BIT];
      state_reg.mouse_mode <= cerr_pkg::DIVISOR_CFG_RESET[cerr_pkg::MOUSE_SEL_BIT];
      state_reg.ignore <= ~cerr_pkg::IGNORE_RESET_LEVEL;
    end
    else
      state_reg <= state_next;
  end

  assign o_ignore_error_out_n = ~state_reg.ignore; // R8
  assign o_fpu_error_request = state_reg.err_mode ? state_reg.err_req
                                                  : ~state_reg.err_sync[1];
  assign o_mouse_request = state_reg.mouse_mode ? state_reg.mouse_latch
                                                : state_reg.mouse_sync[1];

endmodule : coproc_error_mouse_irq
`default_nettype wire

// >>> dv/cerr_sva.sv
// Assertion checker for the error request block
`timescale 1ns/100ps
`default_nettype none
module cerr_sva (input wire logic i_clk, i_rst_n, i_io_write, i_coproc_error_in_n,
  input wire logic o_ignore_error_out_n, o_fpu_error_request,
  input wire logic i_mouse_request_pin, o_mouse_request,
  input wire logic [7:0] i_divisor_cfg, input wire logic [15:0] i_io_addr);
  wire logic e = !i_coproc_error_in_n, g = !o_ignore_error_out_n, m = i_divisor_cfg[5];
  wire logic r = o_fpu_error_request, w = i_io_write && i_io_addr == 16'h00F0;
  wire logic k = i_divisor_cfg[4], p = i_mouse_request_pin;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  reset_out_a: assert property ($rose(i_rst_n) |-> !g && !r) else $error("reset");
  ign_gate_a: assert property (g |-> $past(m, 2) && $past(e, 3)) else $error("gate");
  ign_set_a: assert property ((m && e)[*4] ##0 w |=> g) else $error("set");
  ign_hold_a: assert property (g && $past(e, 2) && $past(m) |=> g) else $error("hold");
  ign_refuse_a: assert property ((!e)[*4] ##0 (w && !g) |=> !g) else $error("refuse");
  req_raise_a: assert property ((m && e)[*4] |=> r) else $error("raise");
  req_keep_a: assert property (r && m && $past(m) && !w |=> r) else $error("keep");
  req_plain_a: assert property ((!m)[*4] |-> r == $past(e, 2)) else $error("plain");
  mouse_plain_a: assert property ((!k)[*4] |-> o_mouse_request == $past(p, 2))
    else $error("mouse plain");
  mouse_latch_a: assert property (k[*3] ##0 ($past(p, 2) && !$past(p, 3)) |=> o_mouse_request)
    else $error("mouse latch");
endmodule : cerr_sva
bind coproc_error_mouse_irq cerr_sva u_sva (.*);
`default_nettype wire

// >>> dv/cpu_model.sv
// Host CPU error pin: low while a fault is pending, pulled high otherwise
`timescale 1ns/100ps
`default_nettype none
module cpu_model (input wire logic i_fault, output logic o_coproc_error_in_n);
  assign o_coproc_error_in_n = !i_fault;
endmodule : cpu_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the error request block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_clk = 0, i_rst_n = 0, i_io_write = 0, i_io_read_strobe_n = 1, f = 0;
  logic i_mouse_request_pin = 0, i_coproc_error_in_n, o_ignore_error_out_n;
  logic o_fpu_error_request, o_mouse_request;
  logic [7:0] i_divisor_cfg = 8'h30;
  logic [15:0] i_io_addr = 16'h00F0;
  int n_errors = 0, comparisons = 0, cyc = 0;
  wire logic [2:0] q = {o_ignore_error_out_n, o_fpu_error_request, o_mouse_request};
  cpu_model CPU (.i_fault(f), .o_coproc_error_in_n(i_coproc_error_in_n));
  coproc_error_mouse_irq DUT (.*);
  initial forever #2.5 i_clk = !i_clk;
  always @(posedge i_clk) if (++cyc > 400) begin n_errors++; give_verdict(); end
  function automatic logic [2:0] plain(input logic a, b); return {1'b1, a, b}; endfunction : plain
  task automatic go(input int n, input logic [2:0] x);
    repeat (n) @(posedge i_clk);
    #1 comparisons++;
    if (q !== x) begin n_errors++; $display("[FAIL] outputs exp %b got %b", x, q); end
  endtask : go
  task automatic give_verdict();
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    void'($urandom(32'hF29C));
    go(6, 3'b100); i_rst_n = 1;
    go(4, 3'b100); i_io_write = 1;
    go(2, 3'b100); i_io_write = 0; f = 1;
    go(4, 3'b110); i_io_write = 1;
    go(2, 3'b010); i_io_write = 0; f = 0;
    go(4, 3'b110); i_io_write = 1;
    go(2, 3'b100); i_io_write = 0; i_mouse_request_pin = 1;
    go(4, 3'b101); i_mouse_request_pin = 0;
    go(4, 3'b101); i_io_read_strobe_n = 0; i_io_addr = 16'h0060;
    go(6, 3'b100); i_io_read_strobe_n = 1;
    repeat (40) begin
      i_divisor_cfg = 8'($urandom) & 8'hCF;
      f = 1'($urandom);
      i_mouse_request_pin = 1'($urandom);
      go(4, plain(f, i_mouse_request_pin));
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
